//--- src/ipv_pkg.sv
/*
 * constants, register map and carrier types of the interrupt priority
 * and vectoring block.
 * assumes a 32-bit AHB-Lite bus and flag images driven by the peripherals.
 */
package ipv_pkg;

	// ****************************************
	// sizes and register map
	// ****************************************
	localparam int         NSRC           = 16;
	localparam logic [7:0] OFS_INT_ENABLE = 8'h00;
	localparam logic [7:0] OFS_INT_PRIO   = 8'h04;
	localparam logic [7:0] OFS_EXT_ENABLE = 8'h08;
	localparam logic [7:0] OFS_EXT_PRIO   = 8'h0C;
	localparam logic [7:0] OFS_CAPT_CTRL  = 8'h10;
	localparam logic [7:0] OFS_STATUS     = 8'h14;
	localparam logic [7:0] REG_RST        = 8'h00;

	// status word layout
	localparam int STAT_VALID_BIT = 8;
	localparam int STAT_LVL_LSB   = 9;
	localparam int STAT_REQ_LSB   = 16;

	// ****************************************
	// levels and per-source tables, index = natural priority
	// ****************************************
	localparam logic [1:0] LVL_LOW     = 2'h0;
	localparam logic [1:0] LVL_HIGH    = 2'h1;
	localparam logic [1:0] LVL_HIGHEST = 2'h2;

	localparam logic [7:0] VECTOR [NSRC] = '{8'h33, 8'h03, 8'h0B, 8'h13, 8'h1B, 8'h23,
		8'h2B, 8'h3B, 8'h43, 8'h4B, 8'h53, 8'h5B, 8'h63, 8'h6B, 8'h73, 8'h7B};
	localparam int FLAG_BIT [NSRC] = '{4, 1, 0, 6, 5, 0, 4, 3, 1, 5, 7, 2, 6, 0, 3, 7};
	localparam int EN_BIT   [NSRC] = '{5, 0, 5, 6, 1, 0, 4, 2, 1, 5, 3, 2, 6, 4, 3, 7};
	// 1 where enable and priority bits sit in the extended registers
	localparam logic [NSRC-1:0] EN_EXT = 16'hDB60;
	localparam int SER_TX_BIT = 1;
	localparam int T2B_BIT    = 4;

	// ****************************************
	// carriers
	// ****************************************
	typedef struct packed {
		logic [7:0] watchdog_control_reg;
		logic [7:0] timer_control_reg;
		logic [7:0] serial1_control;
		logic [7:0] converter_control_reg1;
		logic [7:0] timer2_interrupt_reg;
		logic [7:0] serial0_control;
		logic [7:0] timer2_select_reg;
	} ipv_flags_t;

	typedef struct packed {
		logic       valid;
		logic [1:0] level;
		logic [7:0] vector;
	} ipv_irq_t;

endpackage

//--- src/ipv_ctrl.sv
/*
 * interrupt source collection, priority resolution and vector output,
 * with enable, priority and capture-control registers on AHB-Lite.
 * assumes flag images are synchronous to i_core_clk and that the
 * peripherals owning the flags clear them.
 */
// The placing of the registers and the AHB-Lite interface to the registers were chosen for this implementation.

// How it works
// RULE1 - power fail: vector 33h, natural 0
// RULE2 - external 0: vector 03h, natural 1
// RULE3 - serial 1 rx or tx: 0Bh, natural 2
// RULE4 - converter done: vector 13h, natural 3
// RULE5 - timer 0 overflow: 1Bh, natural 4
// RULE6 - external 2 or capture 0: 23h, 5
// RULE7 - compare match 0: vector 2Bh, 6
// RULE8 - external 1: vector 3Bh, natural 7
// RULE9 - external 3 or capture 1: 43h, 8
// RULE10 - compare match 1: vector 4Bh, 9
// RULE11 - timer 1 overflow: vector 53h, 10
// RULE12 - external 4 or capture 2: 5Bh, 11
// RULE13 - compare match 2: vector 63h, 12
// RULE14 - serial 0 rx or tx: 6Bh, 13
// RULE15 - external 5 or capture 3: 73h, 14
// RULE16 - timer 2 either flag: 7Bh, 15 (code ORs timer2_select_reg[4] with timer 1 overflow, timer_control_reg[7])
// RULE17 - externals 2-5 also need capture control
// RULE18 - three levels, highest only for power fail
// RULE19 - same level: lowest natural number wins
// RULE20 - flag and enable both set to compete
module ipv_ctrl
(
	input  wire logic               i_core_clk,
	input  wire logic               i_resetn,
	input  wire logic               i_hsel,
	input  wire logic [7:0]         i_haddr,
	input  wire logic [1:0]         i_htrans,
	input  wire logic               i_hwrite,
	input  wire logic [2:0]         i_hsize,
	input  wire logic [31:0]        i_hwdata,
	input  wire logic               i_hready,
	output logic      [31:0]        o_hrdata,
	output logic                    o_hreadyout,
	output logic                    o_hresp,
	input  wire ipv_pkg::ipv_flags_t i_flags,
	output ipv_pkg::ipv_irq_t        o_irq
);

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [1:0] src_level(input int i, input logic hi);
		if (i == 0)
			return ipv_pkg::LVL_HIGHEST;
		return hi ? ipv_pkg::LVL_HIGH : ipv_pkg::LVL_LOW;
	endfunction

	// scans downward so that on equal level the lower index wins
	function automatic ipv_pkg::ipv_irq_t arbitrate(input logic [15:0] req,
		input logic [15:0] hi);
		ipv_pkg::ipv_irq_t r;
		r = '0;
		for (int i = ipv_pkg::NSRC - 1; i >= 0; i--)
		begin
			if (req[i] && (!r.valid || src_level(i, hi[i]) >= r.level)) // RULE19
			begin
				r.valid  = 1'b1;
				r.level  = src_level(i, hi[i]); // RULE18
				r.vector = ipv_pkg::VECTOR[i];
			end
		end
		return r;
	endfunction

	// ****************************************
	// registers and bus state
	// ****************************************
	logic [7:0]  int_enable;
	logic [7:0]  int_prio;
	logic [7:0]  ext_enable;
	logic [7:0]  ext_prio;
	logic [7:0]  capt_ctrl;
	logic        dp_write;
	logic [7:0]  dp_addr;
	logic [7:0]  next_int_enable;
	logic [7:0]  next_int_prio;
	logic [7:0]  next_ext_enable;
	logic [7:0]  next_ext_prio;
	logic [7:0]  next_capt_ctrl;
	logic        next_dp_write;
	logic [7:0]  next_dp_addr;
	logic [31:0] next_hrdata;
	logic [15:0] flag;
	logic [15:0] en;
	logic [15:0] hi;
	logic [15:0] req;
	logic [3:0]  ext_cfg;
	ipv_pkg::ipv_irq_t next_irq;

	// ****************************************
	// source collection
	// ****************************************
	always_comb
	begin
		flag[0]  = i_flags.watchdog_control_reg[ipv_pkg::FLAG_BIT[0]]; // RULE1
		flag[1]  = i_flags.timer_control_reg[ipv_pkg::FLAG_BIT[1]]; // RULE2
		flag[2]  = i_flags.serial1_control[ipv_pkg::FLAG_BIT[2]]
			| i_flags.serial1_control[ipv_pkg::SER_TX_BIT]; // RULE3
		flag[3]  = i_flags.converter_control_reg1[ipv_pkg::FLAG_BIT[3]]; // RULE4
		flag[4]  = i_flags.timer_control_reg[ipv_pkg::FLAG_BIT[4]]; // RULE5
		flag[5]  = i_flags.timer2_interrupt_reg[ipv_pkg::FLAG_BIT[5]]; // RULE6
		flag[6]  = i_flags.timer2_interrupt_reg[ipv_pkg::FLAG_BIT[6]]; // RULE7
		flag[7]  = i_flags.timer_control_reg[ipv_pkg::FLAG_BIT[7]]; // RULE8
		flag[8]  = i_flags.timer2_interrupt_reg[ipv_pkg::FLAG_BIT[8]]; // RULE9
		flag[9]  = i_flags.timer2_interrupt_reg[ipv_pkg::FLAG_BIT[9]]; // RULE10
		flag[10] = i_flags.timer_control_reg[ipv_pkg::FLAG_BIT[10]]; // RULE11
		flag[11] = i_flags.timer2_interrupt_reg[ipv_pkg::FLAG_BIT[11]]; // RULE12
		flag[12] = i_flags.timer2_interrupt_reg[ipv_pkg::FLAG_BIT[12]]; // RULE13
		flag[13] = i_flags.serial0_control[ipv_pkg::FLAG_BIT[13]]
			| i_flags.serial0_control[ipv_pkg::SER_TX_BIT]; // RULE14
		flag[14] = i_flags.timer2_interrupt_reg[ipv_pkg::FLAG_BIT[14]]; // RULE15
		flag[15] = i_flags.timer_control_reg[ipv_pkg::FLAG_BIT[15]]
			| i_flags.timer2_select_reg[ipv_pkg::T2B_BIT]; // RULE16
		// an external line counts as configured when its edge pair is non-zero
		for (int k = 0; k < 4; k++)
			ext_cfg[k] = |capt_ctrl[2*k +: 2];
		for (int i = 0; i < ipv_pkg::NSRC; i++)
		begin
			en[i] = ipv_pkg::EN_EXT[i] ? ext_enable[ipv_pkg::EN_BIT[i]]
				: int_enable[ipv_pkg::EN_BIT[i]];
			hi[i] = ipv_pkg::EN_EXT[i] ? ext_prio[ipv_pkg::EN_BIT[i]]
				: int_prio[ipv_pkg::EN_BIT[i]];
		end
		en[0] = i_flags.watchdog_control_reg[ipv_pkg::EN_BIT[0]]; // RULE1
		hi[0] = 1'b0; // RULE18
		en[5]  = en[5] & ext_cfg[0]; // RULE17
		en[8]  = en[8] & ext_cfg[1]; // RULE17
		en[11] = en[11] & ext_cfg[2]; // RULE17
		en[14] = en[14] & ext_cfg[3]; // RULE17
		req = flag & en; // RULE20
		next_irq = arbitrate(req, hi); // RULE20
	end

	always_ff @(posedge i_core_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			o_irq <= '0;
		else
			o_irq <= next_irq;
	end

	// ****************************************
	// AHB-Lite slave, zero wait states
	// ****************************************
	always_comb
	begin
		next_int_enable = int_enable;
		next_int_prio   = int_prio;
		next_ext_enable = ext_enable;
		next_ext_prio   = ext_prio;
		next_capt_ctrl  = capt_ctrl;
		next_hrdata     = '0;
		next_dp_write   = 1'b0;
		next_dp_addr    = dp_addr;
		if (dp_write)
		begin
			unique case (dp_addr)
				ipv_pkg::OFS_INT_ENABLE: next_int_enable = i_hwdata[7:0];
				ipv_pkg::OFS_INT_PRIO:   next_int_prio   = i_hwdata[7:0];
				ipv_pkg::OFS_EXT_ENABLE: next_ext_enable = i_hwdata[7:0];
				ipv_pkg::OFS_EXT_PRIO:   next_ext_prio   = i_hwdata[7:0];
				ipv_pkg::OFS_CAPT_CTRL:  next_capt_ctrl  = i_hwdata[7:0];
				default:                 next_dp_addr    = dp_addr;
			endcase
		end
		if (i_hsel && i_hready && i_htrans[1])
		begin
			next_dp_write = i_hwrite;
			next_dp_addr  = {i_haddr[7:2], 2'h0};
			// read data is latched now, so a status read sees this cycle
			if (!i_hwrite)
			begin
				unique case ({i_haddr[7:2], 2'h0})
					ipv_pkg::OFS_INT_ENABLE: next_hrdata[7:0] = int_enable;
					ipv_pkg::OFS_INT_PRIO:   next_hrdata[7:0] = int_prio;
					ipv_pkg::OFS_EXT_ENABLE: next_hrdata[7:0] = ext_enable;
					ipv_pkg::OFS_EXT_PRIO:   next_hrdata[7:0] = ext_prio;
					ipv_pkg::OFS_CAPT_CTRL:  next_hrdata[7:0] = capt_ctrl;
					ipv_pkg::OFS_STATUS:
					begin
						next_hrdata[7:0] = o_irq.vector;
						next_hrdata[ipv_pkg::STAT_VALID_BIT] = o_irq.valid;
						next_hrdata[ipv_pkg::STAT_LVL_LSB +: 2] = o_irq.level;
						next_hrdata[ipv_pkg::STAT_REQ_LSB +: 16] = req;
					end
					default:                 next_hrdata = '0;
				endcase
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			int_enable  <= ipv_pkg::REG_RST;
			int_prio    <= ipv_pkg::REG_RST;
			ext_enable  <= ipv_pkg::REG_RST;
			ext_prio    <= ipv_pkg::REG_RST;
			capt_ctrl   <= ipv_pkg::REG_RST;
			dp_write    <= 1'b0;
			dp_addr     <= 8'h00;
			o_hrdata    <= 32'h00000000;
			o_hreadyout <= 1'b0;
			o_hresp     <= 1'b0;
		end
		else
		begin
			int_enable  <= next_int_enable;
			int_prio    <= next_int_prio;
			ext_enable  <= next_ext_enable;
			ext_prio    <= next_ext_prio;
			capt_ctrl   <= next_capt_ctrl;
			dp_write    <= next_dp_write;
			dp_addr     <= next_dp_addr;
			o_hrdata    <= next_hrdata;
			o_hreadyout <= 1'b1;
			o_hresp     <= 1'b0;
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_resetn);

	property p_pf_wins;
		req[0] |=> o_irq.valid && o_irq.vector == 8'h33 && o_irq.level == 2'h2;
	endproperty
	a_pf_wins: assert property (p_pf_wins) else $error("power fail lost"); // RULE1

	property p_ex0_alone;
		req == 16'h0002 |=> o_irq.vector == 8'h03 && o_irq.level == $past(hi[1], 1);
	endproperty
	a_ex0_alone: assert property (p_ex0_alone) else $error("ext0 vector wrong"); // RULE2

	property p_ser1_tx;
		i_flags.serial1_control[1] && int_enable[5] |-> req[2];
	endproperty
	a_ser1_tx: assert property (p_ser1_tx) else $error("serial1 tx ignored"); // RULE3

	property p_cm2_alone;
		req == 16'h1000 |=> o_irq.vector == 8'h63;
	endproperty
	a_cm2_alone: assert property (p_cm2_alone) else $error("cm2 vector wrong"); // RULE13

	property p_t2_second;
		i_flags.timer2_select_reg[4] && ext_enable[7] |-> req[15];
	endproperty
	a_t2_second: assert property (p_t2_second) else $error("timer2 flag lost"); // RULE16

	property p_ext2_gate;
		capt_ctrl[1:0] == 2'h0 |-> !req[5];
	endproperty
	a_ext2_gate: assert property (p_ext2_gate) else $error("ext2 not gated"); // RULE17

	property p_high_level;
		!req[0] && (req & hi) != 16'h0000 |=> o_irq.level == 2'h1;
	endproperty
	a_high_level: assert property (p_high_level) else $error("high level lost"); // RULE18

	// a high request elsewhere outranks a low-level tie, so only judge real ties
	property p_natural;
		req[1] && req[15] && !req[0] && hi[1] == hi[15] && (hi[1] || (req & hi) == 16'h0000)
			|=> o_irq.vector == 8'h03;
	endproperty
	a_natural: assert property (p_natural) else $error("tie broken wrong"); // RULE19

	property p_idle;
		req == 16'h0000 |=> !o_irq.valid ##1 (o_irq.valid == ($past(req, 1) != 16'h0000));
	endproperty
	a_idle: assert property (p_idle) else $error("vector without request"); // RULE20

	property p_adc_alone;
		req == 16'h0008 |=> o_irq.vector == 8'h13 && o_irq.level == $past(hi[3], 1);
	endproperty
	a_adc_alone: assert property (p_adc_alone) else $error("converter vector wrong"); // RULE4

	property p_t0_alone;
		req == 16'h0010 |=> o_irq.vector == 8'h1B;
	endproperty
	a_t0_alone: assert property (p_t0_alone) else $error("timer0 vector wrong"); // RULE5

	property p_ser0_tx;
		i_flags.serial0_control[1] && int_enable[4] |-> req[13];
	endproperty
	a_ser0_tx: assert property (p_ser0_tx) else $error("serial0 tx ignored"); // RULE14

	// slave never stalls and never errors once out of reset
	property p_bus_okay;
		$past(i_resetn, 1) |-> o_hreadyout && !o_hresp;
	endproperty
	a_bus_okay: assert property (p_bus_okay) else $error("bus response wrong");

	c_pf:   cover property (req[0] && req[1]);
	c_gate: cover property (i_flags.timer2_interrupt_reg[0] && ext_enable[0] && !req[5]);
	c_read: cover property (i_hsel && i_hready && i_htrans[1] && !i_hwrite);
	c_high: cover property (!req[0] && (req & hi) != 16'h0000 && (req & ~hi) != 16'h0000);
	c_tie:  cover property (req[1] && req[15] && !req[0]);

endmodule

//--- sim/ipv_core_model.sv
/*
 * behavioural processor core: latches the vector it would fetch.
 * assumes o_irq of the controller is registered on i_core_clk.
 */
module ipv_core_model
(
	input  wire logic              i_core_clk,
	input  wire logic              i_resetn,
	input  wire ipv_pkg::ipv_irq_t i_irq,
	output logic [7:0]             o_vector,
	output logic [1:0]             o_level
);
	timeunit 1ns;
	timeprecision 1ps;

	// no acknowledge: the core only follows the standing request
	always_ff @(posedge i_core_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			o_vector <= 8'h00;
			o_level  <= 2'h0;
		end
		else if (i_irq.valid)
		begin
			o_vector <= i_irq.vector;
			o_level  <= i_irq.level;
		end
	end
endmodule

//--- sim/tb.sv
/*
 * self-checking bench of the interrupt priority and vectoring block.
 * assumes the controller is the one AHB-Lite slave and flags are levels.
 */
module tb;
	timeunit 1ns;
	timeprecision 1ps;

	// ****************************************
	// signals and tables, index = natural priority
	// ****************************************
	localparam int IMG [16] = '{0, 1, 2, 3, 1, 4, 4, 1, 4, 4, 1, 4, 4, 5, 4, 6};
	localparam int FB  [16] = '{4, 1, 0, 6, 5, 0, 4, 3, 1, 5, 7, 2, 6, 0, 3, 4};
	localparam int EB  [16] = '{5, 0, 5, 6, 1, 0, 4, 2, 1, 5, 3, 2, 6, 4, 3, 7};
	localparam logic [7:0] RW [5] = '{ipv_pkg::OFS_INT_ENABLE, ipv_pkg::OFS_INT_PRIO,
		ipv_pkg::OFS_EXT_ENABLE, ipv_pkg::OFS_EXT_PRIO, ipv_pkg::OFS_CAPT_CTRL};
	logic                i_core_clk = 1'h0;
	logic                i_resetn   = 1'h0;
	logic                hsel       = 1'h0;
	logic                hwrite     = 1'h0;
	logic [1:0]          htrans     = 2'h0;
	logic [7:0]          haddr      = 8'h00;
	logic [31:0]         hwdata     = 32'h0;
	logic [31:0]         hrdata;
	logic [31:0]         rdata_s;
	logic                hready;
	logic                rdy_s;
	logic                hresp;
	logic                hresp_s;
	logic [7:0]          core_vec;
	ipv_pkg::ipv_flags_t flags      = '0;
	ipv_pkg::ipv_irq_t   irq;
	int                  failures   = 0;
	int                  compares   = 0;

	always #5 i_core_clk = ~i_core_clk;
	// pre-edge values, i.e. what the master samples at that edge
	always @(posedge i_core_clk)
	begin
		rdy_s   <= hready;
		rdata_s <= hrdata;
		hresp_s <= hresp;
	end

	ipv_ctrl ipv_ctrl_inst (.i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_hsel(hsel),
		.i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
		.i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready),
		.o_hresp(hresp), .i_flags(flags), .o_irq(irq));
	ipv_core_model ipv_core_model_inst (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
		.i_irq(irq), .o_vector(core_vec), .o_level());

	// ****************************************
	// tasks
	// ****************************************
	task tally_and_finish;
		$display("compares=%0d failures=%0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task cmp(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			failures++;
			$display("FAIL t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task wait_rdy;
		int k;
		k = 0;
		do
		begin
			@(posedge i_core_clk);
			#1;
			k++;
		end
		while (rdy_s !== 1'h1 && k < 50);
		if (k >= 50)
		begin
			failures++;
			$display("FAIL t=%0t bus hang", $time);
			tally_and_finish();
		end
	endtask

	task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		hsel   <= 1'h1;
		haddr  <= a;
		htrans <= 2'h2;
		hwrite <= wr;
		wait_rdy();
		hsel   <= 1'h0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy();
		rd = rdata_s;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		ahb(1'h1, a, d, r);
	endtask

	task rdchk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		ahb(1'h0, a, 32'h0, r);
		cmp(r, exp);
		cmp({31'h0, hresp_s}, 32'h0);
	endtask

	function automatic logic [55:0] fl(input int n);
		logic [55:0] f;
		f = 56'h0;
		f[(6 - IMG[n]) * 8 + FB[n]] = 1'h1;
		if (n == 0)
			f[53] = 1'h1;
		return f;
	endfunction

	function automatic logic [7:0] vec(input int n);
		if (n == 0)
			return 8'h33;
		return 8'((n < 7) ? 8 * n - 5 : 8 * n + 3);
	endfunction

	task go(input logic [7:0] ie, ip, extended_enable_reg, extended_priority_reg, input logic [55:0] f, input logic [10:0] exp);
		wr(ipv_pkg::OFS_INT_ENABLE, {24'h0, ie});
		wr(ipv_pkg::OFS_INT_PRIO, {24'h0, ip});
		wr(ipv_pkg::OFS_EXT_ENABLE, {24'h0, extended_enable_reg});
		wr(ipv_pkg::OFS_EXT_PRIO, {24'h0, extended_priority_reg});
		flags <= f;
		repeat (3) @(posedge i_core_clk);
		#1;
		cmp({21'h0, irq}, {21'h0, exp});
		if (exp[10])
			cmp({24'h0, core_vec}, {24'h0, exp[7:0]});
	endtask

	// ****************************************
	// sequence
	// ****************************************
	initial
	begin
		logic        ext;
		logic [7:0]  en;
		logic [55:0] fa;
		repeat (5) @(posedge i_core_clk);
		i_resetn <= 1'h1;
		@(posedge i_core_clk);
		#1;
		for (int i = 0; i < 5; i++)
		begin
			rdchk(RW[i], 32'h0);
			wr(RW[i], 32'hFFFF_FF00 | 32'(i * 16 + 3));
			rdchk(RW[i], 32'(i * 16 + 3));
		end
		wr(8'h18, 32'hFF);
		rdchk(8'h18, 32'h0);
		$display("test registers done");
		wr(ipv_pkg::OFS_CAPT_CTRL, 32'h55);
		fa = 56'h0;
		for (int n = 0; n < 16; n++)
		begin
			ext = (IMG[n] == 4) || (n == 15);
			en = 8'(1 << EB[n]);
			fa = fa | fl(n);
			go((ext || n == 0) ? 8'h00 : en, 8'h00, ext ? en : 8'h00, 8'h00, fl(n),
				{1'h1, (n == 0) ? 2'h2 : 2'h0, vec(n)});
			go(8'h00, 8'h00, 8'h00, 8'h00, fl(n) & ~(56'h1 << 53), 11'h000);
		end
		$display("test sources done");
		go(8'hFF, 8'h00, 8'hFF, 8'h00, fa, {3'h6, 8'h33});
		fa[52] = 1'h0;
		go(8'hFF, 8'h00, 8'hFF, 8'h00, fa, {3'h4, 8'h03});
		go(8'hFF, 8'h10, 8'hFF, 8'h00, fa, {3'h5, 8'h6B});
		go(8'hFF, 8'h10, 8'hFF, 8'h80, fa, {3'h5, 8'h6B});
		go(8'h20, 8'h00, 8'h00, 8'h00, 56'h1 << 33, {3'h4, 8'h0B});
		go(8'h00, 8'h00, 8'h80, 8'h00, 56'h1 << 47, {3'h4, 8'h7B});
		rdchk(ipv_pkg::OFS_STATUS, 32'h8000_017B);
		wr(ipv_pkg::OFS_CAPT_CTRL, 32'h0);
		go(8'h00, 8'h00, 8'h01, 8'h00, fl(5), 11'h000);
		wr(ipv_pkg::OFS_CAPT_CTRL, 32'h2);
		go(8'h00, 8'h00, 8'h01, 8'h00, fl(5), {3'h4, 8'h23});
		$display("test priority done");
		tally_and_finish();
	end
endmodule
